/* File: verilog/fsd_pkg.sv */
// Purpose: shared constants for the boot-sector flash host controller
// Assumes: flash bus driven from a 25 MHz clock, up to four bus cycles per request
// Notes:   sector map is the bottom boot arrangement
package fsd_pkg;
    // bus timing, ns and derived cycles at 40 ns
    localparam int CLK_NS        = 40;
    localparam int ACCESS_NS     = 120;
    localparam int WE_PULSE_NS   = 50;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_PULSE_CYC  = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // sector map
    localparam int SECT_W        = 6;
    localparam logic [5:0] SECT_BOOT16  = 6'h00;
    localparam logic [5:0] SECT_BOOT8A  = 6'h01;
    localparam logic [5:0] SECT_BOOT8B  = 6'h02;
    localparam logic [5:0] SECT_BOOT32  = 6'h03;
    localparam logic [5:0] SECT_MAIN0   = 6'h03; // main sectors are a15..a19 plus this
    // identification selector (a1,a0)
    localparam logic [1:0] ID_MAKER     = 2'h0;
    localparam logic [1:0] ID_PART      = 2'h1;
    localparam logic [1:0] ID_PROT      = 2'h2;
    localparam logic [1:0] ID_CONT      = 2'h3;
    localparam logic [7:0] PROT_YES     = 8'h01;
    localparam logic [7:0] PROT_NO      = 8'h00;
    // unlock sequence and commands (word addresses)
    localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
    localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
    localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CMD_RESET    = 8'hf0;
    // request opcodes
    typedef enum logic [2:0] {
        FSD_OP_READ, FSD_OP_WRITE, FSD_OP_ID_HV, FSD_OP_ID_CMD, FSD_OP_PROGRAM
    } fsd_op_t;
endpackage

/* File: verilog/fsd_sector_decode.sv */
// Purpose: map an address onto its bottom boot sector number
// Assumes: word address bits 19..12 given, byte mode already shifted
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module fsd_sector_decode
(
    input  wire logic [19:12]       addrHi,  // word address bits 19..12
    output logic [fsd_pkg::SECT_W-1:0] sector   // sector number
);
    import fsd_pkg::*;
    // boot sectors sit in the first 64 Kbyte, main sectors after it
    always_comb begin
        if (addrHi[19:15] != 5'h00)
            sector = SECT_MAIN0 + {1'b0, addrHi[19:15]};
        else if (addrHi[14])
            sector = SECT_BOOT32;
        else if (!addrHi[13])
            sector = SECT_BOOT16;
        else if (!addrHi[12])
            sector = SECT_BOOT8A;
        else
            sector = SECT_BOOT8B;
    end
endmodule
`default_nettype wire

/* File: verilog/fsd_host.sv */
// Purpose: host that drives a boot-sector flash through its strobes
// Assumes: flash pins are plain logic levels, high voltage shown as flags
// Notes:   one request at a time; busy until its last bus cycle finishes
`timescale 1ns/1ps
`default_nettype none
module fsd_host
#(
    parameter int ACC_CYC = fsd_pkg::ACCESS_CYC,   // read access wait
    parameter int WE_CYC  = fsd_pkg::WE_PULSE_CYC  // write strobe width
) (
    input  wire logic                  mclk,        // system clock
    input  wire logic                  reset,       // async reset, high
    input  wire logic                  reqValid,    // request strobe
    input  wire fsd_pkg::fsd_op_t      reqOp,       // request kind
    input  wire logic [19:0]           reqAddr,     // word address
    input  wire logic                  reqByteLow,  // byte-mode bit a-1
    input  wire logic [15:0]           reqData,     // write data
    input  wire logic                  wordMode,    // bus width select
    input  wire logic                  tempUnprot,  // ask for reset-pin high voltage
    output logic                       reqReady,    // idle, may take request
    output logic                       rspValid,    // read data valid pulse
    output logic [15:0]                rspData,     // read data
    output logic [fsd_pkg::SECT_W-1:0] rspSector,   // sector of the request
    output logic                       rspProt,     // protection status seen
    output logic [19:0]                flAddr,      // flash address pins
    output logic                       flByteLow,   // a-1 in byte mode
    output logic                       flCeN,       // chip select, low
    output logic                       flOeN,       // output enable, low
    output logic                       flWeN,       // write enable, low
    output logic                       flA9Hv,      // elevated voltage on a9
    output logic                       flResetHv,   // elevated voltage on reset pin
    output logic [15:0]                flDqOut,     // data pins out
    output logic                       flDqOe,      // data pins driven
    input  wire logic [15:0]           flDqIn       // data pins in
);
    import fsd_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_READ, S_WRITE, S_GAP} fsd_state_t;

    fsd_state_t        state_r;
    fsd_op_t           op_r;
    logic [2:0]        step_r;      // index in a write sequence
    logic [2:0]        nSteps_r;
    logic [7:0]        wait_r;
    logic [15:0]       dat_r;
    logic [19:0]       addr_r;
    logic [15:0]       dqSync1_r, dqSync2_r, dqSync3_r;
    logic [fsd_pkg::SECT_W-1:0] sect;

    // sector of the request, for callers and protection reads
    // address span
    fsd_sector_decode u_dec (
        .addrHi (reqAddr[19:12]),
        .sector (sect)
    );

    assign reqReady = (state_r == S_IDLE);

    // write sequence for command-driven ops: unlock, unlock, command, data
    function automatic logic [35:0] seqWord(input fsd_op_t op, input logic [2:0] idx,
                                            input logic [19:0] a, input logic [15:0] d);
        logic [19:0] sa;
        logic [15:0] sd;
        sa = UNLOCK_ADDR1;
        sd = {8'h00, UNLOCK_DATA1};
        case (idx)
            3'h1: begin
                sa = UNLOCK_ADDR2;
                sd = {8'h00, UNLOCK_DATA2};
            end
            3'h2: sd = {8'h00, (op == FSD_OP_PROGRAM) ? CMD_PROGRAM : CMD_AUTOSEL};
            3'h3: begin
                sa = a;
                sd = d;
            end
            default: ;
        endcase
        if (op == FSD_OP_WRITE) begin
            sa = a;
            sd = d;
        end
        return {sa, sd};
    endfunction

    // data pins pass three flops; value is used once stages 2 and 3 agree
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dqSync1_r <= 16'h0000;
            dqSync2_r <= 16'h0000;
            dqSync3_r <= 16'h0000;
        end else begin
            dqSync1_r <= flDqIn;
            dqSync2_r <= dqSync1_r;
            dqSync3_r <= dqSync2_r;
        end
    end

    // bus sequencer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r  <= S_IDLE;
            op_r     <= FSD_OP_READ;
            step_r   <= 3'h0;
            nSteps_r <= 3'h0;
            wait_r   <= 8'h00;
            dat_r    <= 16'h0000;
            addr_r   <= 20'h00000;
            flAddr   <= 20'h00000;
            flByteLow <= 1'b0;
            flCeN    <= 1'b1;
            flOeN    <= 1'b1;
            flWeN    <= 1'b1;
            flA9Hv   <= 1'b0;
            flDqOut  <= 16'h0000;
            flDqOe   <= 1'b0;
            rspValid <= 1'b0;
            rspData  <= 16'h0000;
            rspSector <= '0;
            rspProt  <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (reqValid) begin
                        op_r      <= reqOp;
                        addr_r    <= reqAddr;
                        dat_r     <= reqData;
                        rspSector <= sect;
                        flByteLow <= wordMode ? 1'b0 : reqByteLow;
                        step_r    <= 3'h0;
                        case (reqOp)
                            FSD_OP_WRITE:   nSteps_r <= 3'h1;
                            FSD_OP_PROGRAM: nSteps_r <= 3'h4;
                            FSD_OP_ID_CMD:  nSteps_r <= 3'h3;
                            default:        nSteps_r <= 3'h0;
                        endcase
                        state_r <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    flCeN <= 1'b0;
                    if (step_r < nSteps_r) begin
                        {flAddr, flDqOut} <= seqWord(op_r, step_r, addr_r, dat_r);
                        flDqOe  <= 1'b1;
                        flOeN   <= 1'b1;
                        flWeN   <= 1'b0;
                        wait_r  <= 8'(WE_CYC);
                        state_r <= S_WRITE;
                    end else begin
                        flAddr  <= addr_r;
                        flDqOe  <= 1'b0;
                        flWeN   <= 1'b1;
                        flOeN   <= 1'b0;
                        // a9 raise path
                        // control pins stay at logic level: the alternate
                        // protect method is left to programming equipment
                        flA9Hv  <= (op_r == FSD_OP_ID_HV);
                        wait_r  <= 8'(ACC_CYC + 3);
                        state_r <= (op_r == FSD_OP_WRITE || op_r == FSD_OP_PROGRAM)
                                   ? S_GAP : S_READ;
                    end
                end
                S_WRITE: begin
                    if (wait_r <= 8'h01) begin
                        flWeN   <= 1'b1;
                        step_r  <= step_r + 3'h1;
                        state_r <= S_GAP;
                    end else begin
                        wait_r <= wait_r - 8'h01;
                    end
                end
                S_READ: begin
                    if (wait_r <= 8'h01 && dqSync2_r == dqSync3_r) begin
                        rspValid <= 1'b1;
                        rspData  <= wordMode ? dqSync3_r : {8'h00, dqSync3_r[7:0]};
                        rspProt  <= (dqSync3_r[7:0] == PROT_YES);
                        flOeN    <= 1'b1;
                        flA9Hv   <= 1'b0;
                        // step past the read so the gap ends the request
                        step_r   <= step_r + 3'h1;
                        state_r  <= S_GAP;
                    end else if (wait_r > 8'h01) begin
                        wait_r <= wait_r - 8'h01;
                    end
                end
                S_GAP: begin
                    // release select between cycles
                    flCeN  <= 1'b1;
                    flDqOe <= 1'b0;
                    // command-entry id still owes its read once the unlock writes are out
                    if (step_r < nSteps_r || (op_r == FSD_OP_ID_CMD && step_r == nSteps_r))
                        state_r <= S_SETUP;
                    else
                        state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // caller protects first
    // host only raises the pin; the protect-all-then-unprotect order is software's job
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            flResetHv <= 1'b0;
        else
            flResetHv <= tempUnprot;
    end
endmodule
`default_nettype wire

/* File: tb/fsd_host_chk.sv */
// Purpose: port-level protocol checks on the flash host
// Assumes: one clock domain, async high reset
// Notes:   write strobe width taken as the default two cycles
`timescale 1ns/1ps
`default_nettype none
module fsd_host_chk
(
    input wire logic        mclk,       // clock
    input wire logic        reset,      // reset
    input wire logic        wordMode,   // bus width
    input wire logic        tempUnprot, // reset-pin ask
    input wire logic        rspValid,   // read done
    input wire logic [15:0] rspData,    // read data
    input wire logic        rspProt,    // protect flag
    input wire logic        flCeN,      // chip select
    input wire logic        flOeN,      // output enable
    input wire logic        flWeN,      // write enable
    input wire logic        flA9Hv,     // a9 raised
    input wire logic        flResetHv,  // reset pin raised
    input wire logic        flDqOe      // data driven
);
    import fsd_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // write pulse and read launch
    sequence sWeLow; $fell(flWeN) ##1 !flWeN; endsequence
    sequence sRdGo; $fell(flOeN) && !flCeN; endsequence
    chk_reset_idle: assert property ($past(reset) |-> flCeN && flOeN && flWeN && !flDqOe)
        else $error("strobes active after reset");
    chk_write_gate: assert property (!flWeN |-> !flCeN && flOeN)
        else $error("write strobe without select or with read");
    chk_bus_turn: assert property (flDqOe |-> flOeN)
        else $error("data driven during read");
    chk_read_strobes: assert property (!flOeN |-> !flCeN && flWeN)
        else $error("read strobe with bad select or write");
    chk_hv_read: assert property (flA9Hv |-> flWeN && !flDqOe)
        else $error("a9 raised outside a read");
    chk_we_width: assert property (sWeLow |=> flWeN)
        else $error("write pulse width wrong");
    chk_read_answer: assert property (sRdGo |-> ##[4:12] rspValid)
        else $error("read answer missing");
    chk_rsp_pulse: assert property (rspValid |=> !rspValid)
        else $error("answer longer than one cycle");
    chk_prot_flag: assert property (rspValid |-> rspProt == (rspData[7:0] == PROT_YES))
        else $error("protect flag wrong");
    chk_byte_upper: assert property (rspValid && !wordMode |-> rspData[15:8] == 8'h00)
        else $error("upper byte set in byte mode");
    chk_unprot_pin: assert property ($rose(tempUnprot) |-> ##[1:2] flResetHv)
        else $error("reset pin voltage late");
endmodule
bind fsd_host fsd_host_chk i_chk (.mclk(mclk), .reset(reset), .wordMode(wordMode),
    .tempUnprot(tempUnprot), .rspValid(rspValid), .rspData(rspData), .rspProt(rspProt),
    .flCeN(flCeN), .flOeN(flOeN), .flWeN(flWeN), .flA9Hv(flA9Hv),
    .flResetHv(flResetHv), .flDqOe(flDqOe));
`default_nettype wire

/* File: tb/fsd_flash_model.sv */
// Purpose: behavioural bottom boot flash for the host bench
// Assumes: commands in word mode, answers with no delay
// Notes:   protection is set by the bench directly
`timescale 1ns/1ps
`default_nettype none
module fsd_flash_model
#(
    parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
    parameter logic [7:0] PART  = 8'h6c, // arbitrary value
    parameter logic [7:0] UPPER = 8'h3e, // arbitrary value
    parameter logic [7:0] CONT  = 8'h4d  // arbitrary value
) (
    input  wire logic [19:0] flAddr,    // address
    input  wire logic        flByteLow, // a-1
    input  wire logic        flCeN,     // select
    input  wire logic        flOeN,     // read
    input  wire logic        flWeN,     // write
    input  wire logic        flA9Hv,    // a9 raised
    input  wire logic        flResetHv, // reset pin raised
    input  wire logic [15:0] flDqOut,   // data in
    input  wire logic        wordMode,  // x16
    input  wire logic        flDqOe,    // data driven by host
    output logic      [15:0] flDqIn     // data out
);
    import fsd_pkg::*;
    logic [34:0] prot;
    logic [15:0] mem [logic [19:0]];
    logic [1:0]  step, nextStep;
    logic        idMode, progArm, drv;
    logic [15:0] val, last;
    function automatic logic [5:0] secOf(input logic [19:0] a);
        if (a[19:15] != 5'h00) return 6'(a[19:15]) + 6'h03;
        if (a[14]) return 6'h03;
        return a[13] ? {5'h00, a[12]} + 6'h01 : 6'h00;
    endfunction
    initial begin
        prot = '0;
        step = 2'h0;
        idMode = 1'b0;
        progArm = 1'b0;
        last = 16'h0000;
    end
    // write decode
    // a write that does not advance the unlock restarts it; undriven data lines write nothing
    always @(posedge flWeN) if (!flCeN && flOeN && flDqOe) begin
        nextStep = 2'h0;
        if (progArm) begin
            if (!prot[secOf(flAddr)] || flResetHv) mem[flAddr] = flDqOut;
            progArm = 1'b0;
        end else if (flDqOut[7:0] == CMD_RESET) idMode = 1'b0;
        else if (step == 2'h0 && flAddr == UNLOCK_ADDR1 && flDqOut[7:0] == UNLOCK_DATA1)
            nextStep = 2'h1;
        else if (step == 2'h1 && flAddr == UNLOCK_ADDR2 && flDqOut[7:0] == UNLOCK_DATA2)
            nextStep = 2'h2;
        else if (step == 2'h2 && flAddr == UNLOCK_ADDR1) begin
            idMode = flDqOut[7:0] == CMD_AUTOSEL;
            progArm = flDqOut[7:0] == CMD_PROGRAM;
        end
        step = nextStep;
    end
    assign drv = !flCeN && !flOeN;
    always @* begin
        val = mem.exists(flAddr) ? mem[flAddr] : 16'hffff;
        if ((idMode || flA9Hv) && !flAddr[6]) begin
            case (flAddr[1:0])
                ID_MAKER: val = {8'h00, MAKER};
                ID_PART:  val = {UPPER, PART};
                ID_CONT:  val = {8'h00, CONT};
                default:  val = {15'h0000, prot[secOf(flAddr)]};
            endcase
        end
        // upper lines float in byte mode, so give a moving pattern
        if (!wordMode) val = {flAddr[7:0] ^ 8'h5a, flByteLow ? val[15:8] : val[7:0]};
    end
    // released bus shows the inverse of its last value
    always @* if (drv) last = val;
    assign flDqIn = drv ? val : ~last;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the flash host
// Assumes: model answers at once, commands sent in word mode
// Notes:   expected reads queued, a monitor pops and compares
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fsd_pkg::*;
    logic mclk = 0, reset = 1, reqValid = 0, reqByteLow = 0, wordMode = 1, tempUnprot = 0;
    fsd_op_t reqOp = FSD_OP_READ;
    logic [19:0] reqAddr = 0, flAddr;
    logic [15:0] reqData = 0, rspData, flDqOut, flDqIn, d;
    logic [5:0]  rspSector;
    logic reqReady, rspValid, rspProt, flByteLow, flCeN, flOeN, flWeN, flA9Hv, flResetHv, flDqOe;
    logic [22:0] q[$];
    logic [19:0] bnd[10] = '{20'h00000, 20'h01fff, 20'h02000, 20'h02fff, 20'h03000,
                             20'h03fff, 20'h04000, 20'h07fff, 20'h08000, 20'hfffff};
    int n_errors = 0, total_checks = 0;
    fsd_host i_dut (.*);
    fsd_flash_model i_mdl (.*);
    initial forever #20 mclk = ~mclk;
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [22:0] e, logic [22:0] s);
        total_checks++;
        if (e !== s) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // hold the request until an edge samples ready, then wait for idle
    task automatic req(fsd_op_t op, logic [19:0] a, logic [15:0] dv);
        int i;
        reqOp = op;
        reqAddr = a;
        reqData = dv;
        reqValid = 1;
        // ready stands between edges, so the edge after it is seen takes the request
        for (i = 0; i < 400 && reqReady !== 1'b1; i++) tick(1);
        tick(1);
        reqValid = 0;
        while (i < 400 && reqReady !== 1'b1) begin
            tick(1);
            i++;
        end
        if (i >= 400) begin
            chk("ready wait", 0, 1);
            stop_test();
        end
    endtask
    task automatic rd(fsd_op_t op, logic [19:0] a, logic [15:0] e);
        q.push_back({e, i_mdl.secOf(a), e[7:0] == PROT_YES});
        req(op, a, 16'h0000);
    endtask
    // monitor: each answer pulse meets the oldest note
    always @(negedge mclk) if (rspValid === 1'b1) begin
        if (q.size() == 0) chk("spare answer", 0, 1);
        else chk("read", q.pop_front(), {rspData, rspSector, rspProt});
    end
    initial begin
        void'($urandom(32'h33dc));
        tick(8);
        reset = 0;
        foreach (bnd[k]) rd(FSD_OP_READ, bnd[k], 16'hffff);
        repeat (6) rd(FSD_OP_READ, 20'($urandom), 16'hffff);
        i_mdl.prot[5] = 1'b1;
        rd(FSD_OP_ID_HV, 20'h00000, {8'h00, i_mdl.MAKER});
        rd(FSD_OP_ID_HV, 20'h00001, {i_mdl.UPPER, i_mdl.PART});
        rd(FSD_OP_ID_HV, 20'h00003, {8'h00, i_mdl.CONT});
        rd(FSD_OP_ID_HV, 20'h10002, 16'h0001);
        rd(FSD_OP_ID_HV, 20'h20002, 16'h0000);
        rd(FSD_OP_ID_CMD, 20'h00001, {i_mdl.UPPER, i_mdl.PART});
        req(FSD_OP_WRITE, 20'h00000, {8'h00, CMD_RESET});
        d = 16'($urandom);
        req(FSD_OP_PROGRAM, 20'h30000, d);
        rd(FSD_OP_READ, 20'h30000, d);
        req(FSD_OP_PROGRAM, 20'h10000, d);
        rd(FSD_OP_READ, 20'h10000, 16'hffff);
        tempUnprot = 1;
        tick(3);
        req(FSD_OP_PROGRAM, 20'h10001, d);
        rd(FSD_OP_READ, 20'h10001, d);
        tempUnprot = 0;
        tick(3);
        req(FSD_OP_PROGRAM, 20'h10003, d);
        rd(FSD_OP_READ, 20'h10003, 16'hffff);
        req(FSD_OP_WRITE, UNLOCK_ADDR1, {8'h00, CMD_PROGRAM});
        req(FSD_OP_WRITE, 20'h30004, d);
        rd(FSD_OP_READ, 20'h30004, 16'hffff);
        wordMode = 0;
        reqByteLow = 1;
        rd(FSD_OP_READ, 20'h30000, {8'h00, d[15:8]});
        reqByteLow = 0;
        rd(FSD_OP_READ, 20'h30000, {8'h00, d[7:0]});
        tick(20);
        chk("pending notes", 0, 23'(q.size()));
        stop_test();
    end
endmodule
`default_nettype wire
